// ---- apc_pkg.sv ----
package apc_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLOCK_HZ       = 20_000_000;
    localparam int LOCK_TIME_NS   = 5000;
    localparam int NS_PER_S       = 1_000_000_000;
    localparam int LOCK_CYCLES    = (LOCK_TIME_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
    localparam int LOCK_CNT_W     = 16;

    // ------------------------------------------------------------
    // sample words
    // ------------------------------------------------------------
    localparam int SAMPLE_W       = 12;

    // ------------------------------------------------------------
    // four-level strap encoding at the pin sense
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        APC_STRAP_AGND       = 2'h0,
        APC_STRAP_ONE_THIRD  = 2'h1,
        APC_STRAP_TWO_THIRDS = 2'h2,
        APC_STRAP_SUPPLY     = 2'h3
    } apc_strap_e;

    // ------------------------------------------------------------
    // effective configuration carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic format_twos;
        logic dcs_enable;
        logic power_down_chan_a;
        logic power_down_chan_b;
    } apc_cfg_s;

    localparam apc_cfg_s CFG_RESET = '{default: 1'b0};

    // ------------------------------------------------------------
    // timing loop states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        APC_DLL_HOLD    = 3'h1,
        APC_DLL_LOCKING = 3'h2,
        APC_DLL_LOCKED  = 3'h4
    } apc_dll_e;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_DATA   = 12'h008;
    localparam int APB_AW               = 12;

    localparam int CTRL_FORMAT_BIT  = 0;
    localparam int CTRL_DCS_BIT     = 1;
    localparam int CTRL_PD_A_BIT    = 2;
    localparam int CTRL_PD_B_BIT    = 3;

    localparam int STAT_LOCKED_BIT  = 0;
    localparam int STAT_FORMAT_BIT  = 1;
    localparam int STAT_DCS_BIT     = 2;
    localparam int STAT_PD_A_BIT    = 3;
    localparam int STAT_PD_B_BIT    = 4;
    localparam int STAT_SERIAL_BIT  = 5;

    localparam int DATA_A_LSB       = 0;
    localparam int DATA_B_LSB       = 16;

endpackage : apc_pkg

// ---- apc_chan_sampler.sv ----
`timescale 1ns/10ps
module apc_chan_sampler #(
    parameter int WIDTH = apc_pkg::SAMPLE_W
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    // control
    input  wire logic             power_down,
    input  wire logic             format_twos,
    input  wire logic             dll_locked,
    // sample path
    input  wire logic [WIDTH-1:0] sample_in,
    output logic      [WIDTH-1:0] word_out,
    output logic                  valid_out
);

    logic [WIDTH-1:0] word_reg;
    logic [WIDTH-1:0] word_next;
    logic             valid_reg;
    logic             valid_next;

    always_comb
    begin
        word_next  = word_reg;
        valid_next = 1'b0;
        if (!power_down)
        begin
            // raw code is offset binary; flipping the msb gives two's complement
            word_next  = {sample_in[WIDTH-1] ^ format_twos, sample_in[WIDTH-2:0]};
            valid_next = dll_locked;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            word_reg  <= '0;
            valid_reg <= 1'b0;
        end
        else
        begin
            word_reg  <= word_next;
            valid_reg <= valid_next;
        end
    end

    assign word_out  = word_reg;
    assign valid_out = valid_reg;

endmodule : apc_chan_sampler

// ---- apc_pin_config_control.sv ----
`timescale 1ns/10ps
// Overview of operation
// - both channels are sampled at the rising edge of the conversion clock
// - timing loop relocks within several microseconds; data invalid until then
// - strap at supply: two's complement, no duty cycle stabiliser
// - strap at ground: offset binary, no duty cycle stabiliser
// - strap at two thirds: two's complement, stabiliser on
// - strap at one third: offset binary, stabiliser on
// - each channel enters power-down while its power-down input is high
// - serial configuration enable overrides strap and power-down inputs
// - serial bit clock held low while both channels are in power-down
module apc_pin_config_control #(
    parameter int LOCK_CYCLES = apc_pkg::LOCK_CYCLES,
    parameter int SAMPLE_W    = apc_pkg::SAMPLE_W
) (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        reset,
    // static pins
    input  wire logic [1:0]                  format_stabilizer_select,
    input  wire logic                        power_down_chan_a,
    input  wire logic                        power_down_chan_b,
    input  wire logic                        serial_config_enable,
    input  wire logic                        timing_relock,
    // sample inputs
    input  wire logic [SAMPLE_W-1:0]         chan_a_sample,
    input  wire logic [SAMPLE_W-1:0]         chan_b_sample,
    // sample outputs
    output logic      [SAMPLE_W-1:0]         chan_a_word,
    output logic                             chan_a_valid,
    output logic      [SAMPLE_W-1:0]         chan_b_word,
    output logic                             chan_b_valid,
    // status pins
    output logic                             serial_bit_clock,
    output logic                             dcs_enable,
    output logic                             format_twos,
    output logic                             dll_locked,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [apc_pkg::APB_AW-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr
);

    // ------------------------------------------------------------
    // strap decode and effective configuration
    // ------------------------------------------------------------
    apc_pkg::apc_cfg_s strap_reg;
    apc_pkg::apc_cfg_s strap_next;
    apc_pkg::apc_cfg_s ctrl_reg;
    apc_pkg::apc_cfg_s ctrl_next;
    apc_pkg::apc_cfg_s eff_reg;
    apc_pkg::apc_cfg_s eff_next;
    always_comb
    begin
        // fields not set below keep the cleared default
        strap_next = apc_pkg::CFG_RESET;
        case (apc_pkg::apc_strap_e'(format_stabilizer_select))
            apc_pkg::APC_STRAP_SUPPLY:     strap_next.format_twos = 1'b1;
            apc_pkg::APC_STRAP_AGND:       strap_next.format_twos = 1'b0;
            apc_pkg::APC_STRAP_TWO_THIRDS:
            begin
                strap_next.format_twos = 1'b1;
                strap_next.dcs_enable  = 1'b1;
            end
            apc_pkg::APC_STRAP_ONE_THIRD:  strap_next.dcs_enable  = 1'b1;
            default:                       strap_next = apc_pkg::CFG_RESET;
        endcase
        strap_next.power_down_chan_a = power_down_chan_a;
        strap_next.power_down_chan_b = power_down_chan_b;
        // strap is one cycle behind the pins, so eff lags two cycles
        eff_next = serial_config_enable ? ctrl_reg : strap_reg;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            strap_reg <= apc_pkg::CFG_RESET;
            eff_reg   <= apc_pkg::CFG_RESET;
        end
        else
        begin
            strap_reg <= strap_next;
            eff_reg   <= eff_next;
        end
    end

    // ------------------------------------------------------------
    // timing loop lock tracking
    // ------------------------------------------------------------
    apc_pkg::apc_dll_e              dll_reg;
    apc_pkg::apc_dll_e              dll_next;
    logic [apc_pkg::LOCK_CNT_W-1:0] lock_cnt_reg;
    logic [apc_pkg::LOCK_CNT_W-1:0] lock_cnt_next;
    logic                           locked_reg;
    logic                           locked_next;
    localparam logic [apc_pkg::LOCK_CNT_W-1:0] LOCK_LAST = apc_pkg::LOCK_CNT_W'(LOCK_CYCLES - 1);
    always_comb
    begin
        dll_next      = dll_reg;
        lock_cnt_next = lock_cnt_reg;
        // relock held high keeps the loop out of lock whatever its state
        case (dll_reg)
            apc_pkg::APC_DLL_HOLD:
            begin
                lock_cnt_next = '0;
                if (!timing_relock)
                begin
                    dll_next = apc_pkg::APC_DLL_LOCKING;
                end
            end
            apc_pkg::APC_DLL_LOCKING:
            begin
                lock_cnt_next = lock_cnt_reg + 1'b1;
                if (timing_relock)
                begin
                    dll_next = apc_pkg::APC_DLL_HOLD;
                end
                else if (lock_cnt_reg == LOCK_LAST)
                begin
                    dll_next = apc_pkg::APC_DLL_LOCKED;
                end
            end
            apc_pkg::APC_DLL_LOCKED:
            begin
                lock_cnt_next = '0;
                if (timing_relock)
                begin
                    dll_next = apc_pkg::APC_DLL_HOLD;
                end
            end
            default:
            begin
                dll_next      = apc_pkg::APC_DLL_HOLD;
                lock_cnt_next = '0;
            end
        endcase
        locked_next = (dll_next == apc_pkg::APC_DLL_LOCKED);
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            dll_reg      <= apc_pkg::APC_DLL_LOCKING;
            lock_cnt_reg <= '0;
            locked_reg   <= 1'b0;
        end
        else
        begin
            dll_reg      <= dll_next;
            lock_cnt_reg <= lock_cnt_next;
            locked_reg   <= locked_next;
        end
    end

    // ------------------------------------------------------------
    // channel samplers
    // ------------------------------------------------------------
    apc_chan_sampler #(.WIDTH(SAMPLE_W)) u_chan_a (
        .clock       (clock),
        .reset       (reset),
        .power_down  (eff_reg.power_down_chan_a),
        .format_twos (eff_reg.format_twos),
        .dll_locked  (locked_reg),
        .sample_in   (chan_a_sample),
        .word_out    (chan_a_word),
        .valid_out   (chan_a_valid)
    );

    apc_chan_sampler #(.WIDTH(SAMPLE_W)) u_chan_b (
        .clock       (clock),
        .reset       (reset),
        .power_down  (eff_reg.power_down_chan_b),
        .format_twos (eff_reg.format_twos),
        .dll_locked  (locked_reg),
        .sample_in   (chan_b_sample),
        .word_out    (chan_b_word),
        .valid_out   (chan_b_valid)
    );

    // ------------------------------------------------------------
    // serial bit clock and status pins
    // ------------------------------------------------------------
    logic sbc_reg;
    logic sbc_next;
    logic dcs_reg;
    logic fmt_reg;
    always_comb
    begin
        // device counts as powered down only with both channels down
        sbc_next = (eff_reg.power_down_chan_a && eff_reg.power_down_chan_b) ? 1'b0 : ~sbc_reg;
    end
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            sbc_reg <= 1'b0;
            dcs_reg <= 1'b0;
            fmt_reg <= 1'b0;
        end
        else
        begin
            sbc_reg <= sbc_next;
            dcs_reg <= eff_reg.dcs_enable;
            fmt_reg <= eff_reg.format_twos;
        end
    end

    // ------------------------------------------------------------
    // apb slave: no wait states, pready raised for the first access-phase cycle
    // ------------------------------------------------------------
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        ready_reg;
    logic        ready_next;
    logic        err_reg;
    logic        err_next;
    logic        mapped;
    always_comb
    begin
        ctrl_next  = ctrl_reg;
        rdata_next = rdata_reg;
        ready_next = psel && !penable;
        err_next   = 1'b0;
        mapped     = (paddr == apc_pkg::ADDR_CTRL) || (paddr == apc_pkg::ADDR_STATUS) ||
                     (paddr == apc_pkg::ADDR_DATA);
        if (psel && !penable)
        begin
            err_next   = !mapped || (pwrite && paddr != apc_pkg::ADDR_CTRL);
            rdata_next = '0;
            if (!pwrite)
            begin
                case (paddr)
                    apc_pkg::ADDR_CTRL:
                    begin
                        rdata_next[apc_pkg::CTRL_FORMAT_BIT] = ctrl_reg.format_twos;
                        rdata_next[apc_pkg::CTRL_DCS_BIT]    = ctrl_reg.dcs_enable;
                        rdata_next[apc_pkg::CTRL_PD_A_BIT]   = ctrl_reg.power_down_chan_a;
                        rdata_next[apc_pkg::CTRL_PD_B_BIT]   = ctrl_reg.power_down_chan_b;
                    end
                    apc_pkg::ADDR_STATUS:
                    begin
                        rdata_next[apc_pkg::STAT_LOCKED_BIT] = locked_reg;
                        rdata_next[apc_pkg::STAT_FORMAT_BIT] = eff_reg.format_twos;
                        rdata_next[apc_pkg::STAT_DCS_BIT]    = eff_reg.dcs_enable;
                        rdata_next[apc_pkg::STAT_PD_A_BIT]   = eff_reg.power_down_chan_a;
                        rdata_next[apc_pkg::STAT_PD_B_BIT]   = eff_reg.power_down_chan_b;
                        rdata_next[apc_pkg::STAT_SERIAL_BIT] = serial_config_enable;
                    end
                    apc_pkg::ADDR_DATA:
                    begin
                        rdata_next[apc_pkg::DATA_A_LSB +: SAMPLE_W] = chan_a_word;
                        rdata_next[apc_pkg::DATA_B_LSB +: SAMPLE_W] = chan_b_word;
                    end
                    default: rdata_next = '0;
                endcase
            end
        end
        if (psel && penable && ready_reg && pwrite && paddr == apc_pkg::ADDR_CTRL)
        begin
            ctrl_next.format_twos       = pwdata[apc_pkg::CTRL_FORMAT_BIT];
            ctrl_next.dcs_enable        = pwdata[apc_pkg::CTRL_DCS_BIT];
            ctrl_next.power_down_chan_a = pwdata[apc_pkg::CTRL_PD_A_BIT];
            ctrl_next.power_down_chan_b = pwdata[apc_pkg::CTRL_PD_B_BIT];
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            ctrl_reg  <= apc_pkg::CFG_RESET;
            rdata_reg <= '0;
            ready_reg <= 1'b0;
            err_reg   <= 1'b0;
        end
        else
        begin
            ctrl_reg  <= ctrl_next;
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            err_reg   <= err_next;
        end
    end

    assign serial_bit_clock = sbc_reg;
    assign dcs_enable       = dcs_reg;
    assign format_twos      = fmt_reg;
    assign dll_locked       = locked_reg;
    assign prdata           = rdata_reg;
    assign pready           = ready_reg;
    assign pslverr          = err_reg;
endmodule : apc_pin_config_control

// ---- apc_pin_config_control_checker.sv ----
`timescale 1ns/10ps
module apc_pin_config_control_checker #(
    parameter int LOCK_CYCLES = 100,
    parameter int SAMPLE_W    = 12
) (
    // clock and reset
    input wire logic                clock,
    input wire logic                reset,
    // static pins
    input wire logic [1:0]          format_stabilizer_select,
    input wire logic                power_down_chan_a,
    input wire logic                power_down_chan_b,
    input wire logic                serial_config_enable,
    input wire logic                timing_relock,
    // sample path
    input wire logic [SAMPLE_W-1:0] chan_a_sample,
    input wire logic [SAMPLE_W-1:0] chan_a_word,
    input wire logic                chan_a_valid,
    input wire logic                chan_b_valid,
    // status pins
    input wire logic                serial_bit_clock,
    input wire logic                dcs_enable,
    input wire logic                format_twos,
    input wire logic                dll_locked
);
    // slack covers the cycle spent leaving hold ahead of the lock count
    localparam int LOCK_LO = LOCK_CYCLES - 1;
    localparam int LOCK_HI = LOCK_CYCLES + 3;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    // --------------------------------
    // sequences
    // --------------------------------
    sequence s_strap_steady;
        (!serial_config_enable && $stable(format_stabilizer_select))[*5];
    endsequence
    sequence s_chan_a_live;
        (!power_down_chan_a && dll_locked)[*5];
    endsequence
    sequence s_lock_regain;
        !dll_locked ##[LOCK_LO:LOCK_HI] dll_locked;
    endsequence

    // --------------------------------
    // assertions
    // --------------------------------
    a_strap_format: assert property (
        s_strap_steady |-> format_twos == format_stabilizer_select[1])
        else $error("format pin off strap");
    a_strap_dcs: assert property (
        s_strap_steady |-> dcs_enable == (format_stabilizer_select[1] ^ format_stabilizer_select[0]))
        else $error("stabiliser pin off strap");
    a_sample_rise: assert property (
        (s_strap_steady and s_chan_a_live) |=> chan_a_word == {$past(chan_a_sample[SAMPLE_W-1])
        ^ $past(format_stabilizer_select[1]), $past(chan_a_sample[SAMPLE_W-2:0])})
        else $error("word not from this edge");
    a_chan_a_down: assert property (
        (!serial_config_enable && power_down_chan_a)[*5] |-> !chan_a_valid)
        else $error("channel a live in power-down");
    a_chan_b_down: assert property (
        (!serial_config_enable && power_down_chan_b)[*5] |-> !chan_b_valid)
        else $error("channel b live in power-down");
    a_bitclk_parked: assert property (
        (!serial_config_enable && power_down_chan_a && power_down_chan_b)[*5] |-> !serial_bit_clock)
        else $error("bit clock not parked low");
    a_bitclk_running: assert property (
        (!serial_config_enable && !power_down_chan_a)[*5] |-> serial_bit_clock != $past(serial_bit_clock))
        else $error("bit clock stalled");
    a_relock_drop: assert property (
        timing_relock |=> !dll_locked)
        else $error("lock kept during relock");
    a_lock_regain: assert property (
        $fell(timing_relock) |-> s_lock_regain)
        else $error("lock not regained in time");
    a_valid_gate: assert property (
        !dll_locked |=> !chan_a_valid && !chan_b_valid)
        else $error("valid while unlocked");
endmodule : apc_pin_config_control_checker

bind apc_pin_config_control apc_pin_config_control_checker #(
    .LOCK_CYCLES(LOCK_CYCLES),
    .SAMPLE_W(SAMPLE_W)
) u_chk (
    .clock(clock), .reset(reset), .format_stabilizer_select(format_stabilizer_select),
    .power_down_chan_a(power_down_chan_a), .power_down_chan_b(power_down_chan_b),
    .serial_config_enable(serial_config_enable), .timing_relock(timing_relock),
    .chan_a_sample(chan_a_sample), .chan_a_word(chan_a_word), .chan_a_valid(chan_a_valid),
    .chan_b_valid(chan_b_valid), .serial_bit_clock(serial_bit_clock), .dcs_enable(dcs_enable),
    .format_twos(format_twos), .dll_locked(dll_locked)
);

// ---- apc_pin_driver.sv ----
`timescale 1ns/10ps
module apc_pin_driver #(
    parameter int PULSE_CYCLES = 20
) (
    // clock
    input  wire logic       clock,
    // bench requests
    input  wire logic       relock_req,
    input  wire logic [1:0] strap_want,
    input  wire logic       pd_a_want,
    input  wire logic       pd_b_want,
    input  wire logic       sce_want,
    // pins toward the device
    output logic      [1:0] format_stabilizer_select,
    output logic            power_down_chan_a,
    output logic            power_down_chan_b,
    output logic            serial_config_enable,
    output logic            timing_relock
);
    logic [7:0] pulse_reg;

    initial
    begin
        format_stabilizer_select = 2'h0;
        {power_down_chan_a, power_down_chan_b, serial_config_enable} = 3'h0;
        pulse_reg = 8'h00;
    end

    // static levels only move just after an edge
    always @(posedge clock)
    begin
        format_stabilizer_select <= strap_want;
        power_down_chan_a        <= pd_a_want;
        power_down_chan_b        <= pd_b_want;
        serial_config_enable     <= sce_want;
        if (relock_req)
            pulse_reg <= 8'(PULSE_CYCLES);
        else if (pulse_reg != 8'h00)
            pulse_reg <= pulse_reg - 8'h01;
    end

    // one microsecond high, low the rest of the time
    assign timing_relock = (pulse_reg != 8'h00);
endmodule : apc_pin_driver

// ---- apc_pin_config_control_tb.sv ----
`timescale 1ns/10ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module apc_pin_config_control_tb;
    localparam int LOCK = 4;
    localparam int WAIT = 200;

    // clock, reset, counters
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    int          error_cnt = 0;
    int          n_compared = 0;
    logic [31:0] seed = 32'h0000b1d4;
    // partner side
    logic        relock_req = 1'b0;
    logic [1:0]  strap_want = 2'h0;
    logic        pd_a_want = 1'b0;
    logic        pd_b_want = 1'b0;
    logic        sce_want = 1'b0;
    logic [1:0]  format_stabilizer_select;
    logic        power_down_chan_a, power_down_chan_b, serial_config_enable, timing_relock;
    // samples and status
    logic [11:0] chan_a_sample = 12'h000;
    logic [11:0] chan_b_sample = 12'h000;
    logic [11:0] chan_a_word, chan_b_word, held;
    logic        chan_a_valid, chan_b_valid, serial_bit_clock, dcs_enable, format_twos, dll_locked;
    // apb
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, q, r;
    logic        pready, pslverr, err;

    always #25 clock = ~clock;

    apc_pin_driver PARTNER (.clock, .relock_req, .strap_want, .pd_a_want, .pd_b_want, .sce_want,
        .format_stabilizer_select, .power_down_chan_a, .power_down_chan_b, .serial_config_enable, .timing_relock);
    apc_pin_config_control #(.LOCK_CYCLES(LOCK), .SAMPLE_W(12)) DUT (.clock, .reset, .format_stabilizer_select,
        .power_down_chan_a, .power_down_chan_b, .serial_config_enable, .timing_relock, .chan_a_sample,
        .chan_b_sample, .chan_a_word, .chan_a_valid, .chan_b_word, .chan_b_valid, .serial_bit_clock,
        .dcs_enable, .format_twos, .dll_locked, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // raw codes are offset binary: two's complement flips the msb only
    function automatic logic [11:0] exp_word(input logic [11:0] s, input logic twos);
        return {s[11] ^ twos, s[10:0]};
    endfunction : exp_word

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < WAIT);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            error_cnt++;
            close_out();
        end
        @(posedge clock);
    endtask : apb

    task automatic wait_lock();
        int n;
        n = 0;
        while (dll_locked !== 1'b1 && n < WAIT)
        begin
            @(posedge clock);
            n++;
        end
        `CHK(dll_locked, 1'b1)
        if (dll_locked !== 1'b1)
            close_out();
        repeat (2) @(posedge clock);
    endtask : wait_lock

    // new sample every edge; word must carry the one taken at that edge
    task automatic run_samples(input logic twos);
        logic [31:0] prev;
        prev = 32'h0;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clock);
            r = (i == 1) ? 32'h0fff0000 : (i == 2) ? 32'h08000800 : rnd();
            chan_a_sample <= r[11:0];
            chan_b_sample <= r[27:16];
            #1;
            if (i > 0)
            begin
                `CHK(chan_a_word, exp_word(prev[11:0], twos))
                `CHK(chan_b_word, exp_word(prev[27:16], twos))
                `CHK(chan_a_valid & chan_b_valid, 1'b1)
            end
            prev = r;
        end
        @(posedge clock);
    endtask : run_samples

    initial
    begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        wait_lock();
        for (int s = 0; s < 4; s++)
        begin
            strap_want <= s[1:0];
            repeat (8) @(posedge clock);
            `CHK(format_twos, s[1])
            `CHK(dcs_enable, s[1] ^ s[0])
            apb(1'b0, apc_pkg::ADDR_STATUS, 32'h0);
            `CHK(q[5:0], {3'h0, s[1] ^ s[0], s[1], 1'b1})
            run_samples(s[1]);
        end
        pd_a_want <= 1'b1;
        repeat (8) @(posedge clock);
        held = chan_a_word;
        `CHK({chan_a_valid, chan_b_valid}, 2'b01)
        chan_a_sample <= ~chan_a_sample;
        repeat (3) @(posedge clock);
        `CHK(chan_a_word, held)
        pd_b_want <= 1'b1;
        repeat (8) @(posedge clock);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock);
            `CHK(serial_bit_clock, 1'b0)
        end
        // serial enable must beat both downs and the strap
        strap_want <= 2'h0;
        apb(1'b1, apc_pkg::ADDR_CTRL, 32'h00000003);
        sce_want <= 1'b1;
        repeat (8) @(posedge clock);
        `CHK({format_twos, dcs_enable, chan_a_valid}, 3'b111)
        held[0] = serial_bit_clock;
        @(posedge clock);
        `CHK(serial_bit_clock, ~held[0])
        run_samples(1'b1);
        apb(1'b1, apc_pkg::ADDR_CTRL, 32'h00000004);
        repeat (8) @(posedge clock);
        `CHK({format_twos, chan_a_valid, chan_b_valid}, 3'b001)
        apb(1'b0, apc_pkg::ADDR_CTRL, 32'h0);
        `CHK(q[3:0], 4'h4)
        apb(1'b0, apc_pkg::ADDR_STATUS, 32'h0);
        `CHK(q[5:0], 6'b101001)
        {sce_want, pd_a_want, pd_b_want} <= 3'h0;
        chan_a_sample <= 12'h123;
        chan_b_sample <= 12'hedc;
        repeat (8) @(posedge clock);
        `CHK({format_twos, chan_a_valid}, 2'b01)
        apb(1'b0, apc_pkg::ADDR_DATA, 32'h0);
        `CHK(q, {4'h0, exp_word(12'hedc, 1'b0), 4'h0, exp_word(12'h123, 1'b0)})
        apb(1'b0, 12'hffc, 32'h0);
        `CHK({err, q}, {1'b1, 32'h0})
        apb(1'b1, apc_pkg::ADDR_STATUS, 32'hffffffff);
        `CHK(err, 1'b1)
        relock_req <= 1'b1;
        @(posedge clock);
        relock_req <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK({dll_locked, chan_a_valid}, 2'b00)
        wait_lock();
        run_samples(1'b0);
        close_out();
    end
endmodule : apc_pin_config_control_tb
